// [src/dbc_cfg.svh]
// constants for the dual bridge chopper control block
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH

// structure
`define DBC_NUM_BRIDGES 2
`define DBC_ADDR_W 8
`define DBC_DATA_W 32
`define DBC_CNT_W 16

// clock and timing
`define DBC_CLK_PERIOD_NS 5
`define DBC_DEAD_NS 3000
`define DBC_DEAD_CYC ((`DBC_DEAD_NS + `DBC_CLK_PERIOD_NS - 1) / `DBC_CLK_PERIOD_NS)
`define DBC_TRIP_LAT_NS 2000
`define DBC_TRIP_LAT_CYC (`DBC_TRIP_LAT_NS / `DBC_CLK_PERIOD_NS)
`define DBC_OFF_DEFAULT_NS 10000
`define DBC_OFF_DEFAULT_CYC (`DBC_OFF_DEFAULT_NS / `DBC_CLK_PERIOD_NS)

// register offsets
`define DBC_OFFTIME0_ADDR 8'h00
`define DBC_OFFTIME1_ADDR 8'h04
`define DBC_CTRL_ADDR 8'h08
`define DBC_STATUS_ADDR 8'h0c

// status field positions
`define DBC_ST_STATE0_LSB 0
`define DBC_ST_STATE1_LSB 4
`define DBC_ST_THERM_BIT 8
`define DBC_ST_TRIP_LSB 9
`define DBC_ST_LEVEL_LSB 12

// reset values
`define DBC_CTRL_RST 2'h0
`define DBC_PIN_RST 1'h1
`define DBC_THERM_RST 1'h0

`endif

// [src/dbc_pkg.sv]
// types shared by the dual bridge chopper control block
package dbc_pkg;

  // bridge control state
  typedef enum logic [2:0] {
    DBC_OFF = 3'h0,
    DBC_DEAD = 3'h1,
    DBC_DRIVE = 3'h2,
    DBC_CHOP = 3'h3,
    DBC_HOLD = 3'h4
  } dbc_state_e;

  // decoded current level
  typedef enum logic [1:0] {
    DBC_LVL_FULL = 2'h0,
    DBC_LVL_TWO_THIRDS = 2'h1,
    DBC_LVL_ONE_THIRD = 2'h2,
    DBC_LVL_ZERO = 2'h3
  } dbc_level_e;

  // logic pins of one bridge, as seen at the package
  typedef struct packed {
    logic phase;
    logic enable_n;
    logic current_sel_lo;
    logic current_sel_hi;
    logic trip;
  } dbc_pins_s;

  // drive of one bridge's two outputs
  typedef struct packed {
    logic bridge_out_a;
    logic bridge_oe_a;
    logic bridge_out_b;
    logic bridge_oe_b;
  } dbc_drive_s;

endpackage

// [src/dbc_sync.sv]
// two-flop synchroniser for asynchronous pin inputs
module dbc_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // first stage is read only by the second
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // both stages reset to the idle level of the pins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// [src/dbc_timer.sv]
// loadable down counter used for off time and dead time
`include "dbc_cfg.svh"
module dbc_timer
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [`DBC_CNT_W-1:0] value_i,
  output logic done_o
);

  // remaining cycles
  logic [`DBC_CNT_W-1:0] count_q;
  logic [`DBC_CNT_W-1:0] count_d;

  // load wins, otherwise count down and stop at zero
  assign count_d = load_i ? value_i :
                   (count_q != '0) ? count_q - `DBC_CNT_W'(1) : count_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // expired; a fresh load hides the old zero
  assign done_o = (count_q == '0) && !load_i;

endmodule

// [src/dbc_top.sv]
// dual full-bridge chopper control: pins, chopper, dead time, thermal gate
//
// What this block does
// - comparator trip fires one-shot, source driver off
// - trip to source-off well inside 2 us
// - sink stays on during off interval
// - source re-enabled after off time expires
// - no re-enable while comparator still tripped
// - select pins decode to 100/67/33/0 percent
// - zero-current code turns all four drivers off
// - phase high gives a high, b low
// - enable high puts both outputs in high impedance
// - phase change inserts 3 us dead time
// - enable off or zero code: all drivers off
// - undriven inputs read high, so enable is off
// - over-temperature shuts drivers, hysteresis to re-enable
`include "dbc_cfg.svh"
module dbc_top
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  // register port
  input wire logic [`DBC_ADDR_W-1:0] addr_i,
  input wire logic [`DBC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DBC_DATA_W-1:0] rdata_o,
  // logic pins of both bridges, asynchronous
  input wire dbc_pins_s [`DBC_NUM_BRIDGES-1:0] pins_i,
  // thermal sensor flags, asynchronous
  input wire logic temp_hot_i,
  input wire logic temp_cool_i,
  // bridge drive, registered
  output dbc_drive_s [`DBC_NUM_BRIDGES-1:0] drive_o,
  // decoded current level per bridge, for the reference scaler
  output dbc_level_e [`DBC_NUM_BRIDGES-1:0] level_o,
  // thermal shutdown in force
  output logic therm_off_o
);

  localparam int NB = `DBC_NUM_BRIDGES;
  localparam int PW = $bits(dbc_pins_s);

  // dead time load value: count runs to zero inclusive
  localparam logic [`DBC_CNT_W-1:0] DEAD_LOAD = `DBC_CNT_W'(`DBC_DEAD_CYC - 1);
  // reset off time in cycles
  localparam logic [`DBC_CNT_W-1:0] OFF_RST = `DBC_CNT_W'(`DBC_OFF_DEFAULT_CYC);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------

  // bridge pins after two flops
  dbc_pins_s [NB-1:0] pins_s;
  // thermal flags after two flops
  logic [1:0] therm_s;

  // pins reset high: an open pin reads as high, so enable is off
  dbc_sync #(
    .WIDTH(NB * PW),
    .RST_VAL(`DBC_PIN_RST)
  ) u_pin_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .d_i(pins_i),
    .q_o(pins_s)
  );

  // comparator trip is inside pins_s, so it is synchronised too

  // thermal flags reset inactive
  dbc_sync #(
    .WIDTH(2),
    .RST_VAL(`DBC_THERM_RST)
  ) u_therm_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .d_i({temp_hot_i, temp_cool_i}),
    .q_o(therm_s)
  );

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------

  // programmed off time per bridge, in clock cycles
  logic [`DBC_CNT_W-1:0] offtime_q [NB];
  // software force-off per bridge
  logic [NB-1:0] ctrl_q;
  // registered read data
  logic [`DBC_DATA_W-1:0] rdata_q;
  logic [`DBC_DATA_W-1:0] rdata_d;

  // address decode
  wire hit_off0 = (addr_i == `DBC_OFFTIME0_ADDR);
  wire hit_off1 = (addr_i == `DBC_OFFTIME1_ADDR);
  wire hit_ctrl = (addr_i == `DBC_CTRL_ADDR);
  wire hit_stat = (addr_i == `DBC_STATUS_ADDR);

  // status word built from the bridge state below
  logic [`DBC_DATA_W-1:0] status_word;

  // writes: one cycle, no wait states
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offtime_q[0] <= OFF_RST;
      offtime_q[1] <= OFF_RST;
      ctrl_q <= `DBC_CTRL_RST;
    end else if (wr_i) begin
      // unmapped writes are dropped
      if (hit_off0) begin
        offtime_q[0] <= wdata_i[`DBC_CNT_W-1:0];
      end
      if (hit_off1) begin
        offtime_q[1] <= wdata_i[`DBC_CNT_W-1:0];
      end
      if (hit_ctrl) begin
        ctrl_q <= wdata_i[NB-1:0];
      end
    end
  end

  // read mux; unmapped reads give zero
  assign rdata_d = !rd_i ? '0 :
                   hit_off0 ? `DBC_DATA_W'(offtime_q[0]) :
                   hit_off1 ? `DBC_DATA_W'(offtime_q[1]) :
                   hit_ctrl ? `DBC_DATA_W'(ctrl_q) :
                   hit_stat ? status_word : '0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // thermal shutdown with hysteresis
  // ---------------------------------------------------------------

  // the sensor gives two flags: hot (170 C reached) and cool (below 145 C);
  // the band between them is held by this latch
  logic therm_q;
  wire therm_hot = therm_s[1];
  wire therm_cool = therm_s[0];

  // hot sets, cool clears; set wins if both arrive together
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      therm_q <= 1'b0;
    end else if (therm_hot) begin
      therm_q <= 1'b1;
    end else if (therm_cool) begin
      therm_q <= 1'b0;
    end
  end

  assign therm_off_o = therm_q;

  // ---------------------------------------------------------------
  // per-bridge chopper and dead time
  // ---------------------------------------------------------------

  // per-bridge state, gathered for status
  dbc_state_e [NB-1:0] state_all;
  logic [NB-1:0] trip_all;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bridge

      // state machine registers
      dbc_state_e state_q;
      dbc_state_e state_d;
      // phase applied to the outputs, lags the pin through dead time
      logic phase_q;
      logic phase_d;
      // registered output drive
      dbc_drive_s drive_q;
      dbc_drive_s drive_d;
      // timer control
      logic tmr_load;
      logic [`DBC_CNT_W-1:0] tmr_value;
      logic tmr_done;

      // decoded inputs
      wire sel_lo = pins_s[b].current_sel_lo;
      wire sel_hi = pins_s[b].current_sel_hi;
      wire trip = pins_s[b].trip;
      wire phase_pin = pins_s[b].phase;
      dbc_level_e level;

      // current level: lo alone 67, hi alone 33, both zero
      assign level = (!sel_lo && !sel_hi) ? DBC_LVL_FULL :
                     ( sel_lo && !sel_hi) ? DBC_LVL_TWO_THIRDS :
                     (!sel_lo &&  sel_hi) ? DBC_LVL_ONE_THIRD : DBC_LVL_ZERO;

      // bridge may conduct: enable low, nonzero code, cool, not forced off
      wire allowed = !pins_s[b].enable_n
                     && (level != DBC_LVL_ZERO)
                     && !therm_q
                     && !ctrl_q[b];

      // direction pin differs from the applied phase
      wire phase_change = (phase_pin != phase_q);

      // off time of zero still gives one cycle
      wire [`DBC_CNT_W-1:0] off_len = (offtime_q[b] == '0) ? `DBC_CNT_W'(1) : offtime_q[b];

      // next state; disallow beats every other branch
      always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        tmr_load = 1'b0;
        tmr_value = '0;
        if (!allowed) begin
          // all four drivers off, fast decay
          state_d = DBC_OFF;
        end else begin
          unique case (state_q)
            DBC_OFF: begin
              // drivers were off, so no crossover to guard
              state_d = DBC_DRIVE;
              phase_d = phase_pin;
            end
            DBC_DEAD: begin
              // drivers off until the dead time runs out
              if (tmr_done) begin
                state_d = DBC_DRIVE;
                phase_d = phase_pin;
              end
            end
            DBC_DRIVE: begin
              if (phase_change) begin
                // new direction: go through dead time
                state_d = DBC_DEAD;
                tmr_load = 1'b1;
                tmr_value = DEAD_LOAD;
              end else if (trip) begin
                // fire the one-shot and drop the source side
                state_d = DBC_CHOP;
                tmr_load = 1'b1;
                tmr_value = off_len - `DBC_CNT_W'(1);
              end
            end
            DBC_CHOP: begin
              if (phase_change) begin
                state_d = DBC_DEAD;
                tmr_load = 1'b1;
                tmr_value = DEAD_LOAD;
              end else if (tmr_done) begin
                // off time over: resume only once current is below trip
                state_d = trip ? DBC_HOLD : DBC_DRIVE;
              end
            end
            DBC_HOLD: begin
              if (phase_change) begin
                state_d = DBC_DEAD;
                tmr_load = 1'b1;
                tmr_value = DEAD_LOAD;
              end else if (!trip) begin
                // current has decayed below trip, source back on
                state_d = DBC_DRIVE;
              end
            end
            default: begin
              // spare codes recover to off
              state_d = DBC_OFF;
            end
          endcase
        end
      end

      // one timer per bridge serves off time and dead time
      dbc_timer u_timer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .value_i(tmr_value),
        .done_o(tmr_done)
      );

      // output decode from the state
      always_comb begin
        drive_d = '0;
        unique case (state_d)
          DBC_DRIVE: begin
            // phase high: a high, b low
            drive_d.bridge_out_a = phase_d;
            drive_d.bridge_out_b = !phase_d;
            drive_d.bridge_oe_a = 1'b1;
            drive_d.bridge_oe_b = 1'b1;
          end
          DBC_CHOP, DBC_HOLD: begin
            // only the low (sink) side stays driven; source side released
            drive_d.bridge_out_a = 1'b0;
            drive_d.bridge_out_b = 1'b0;
            drive_d.bridge_oe_a = !phase_d;
            drive_d.bridge_oe_b = phase_d;
          end
          default: begin
            // off and dead time: both outputs high impedance
            drive_d = '0;
          end
        endcase
      end

      // state, applied phase and drive; outputs come from flops, so the
      // source turns off two sync cycles plus one edge after the trip
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          state_q <= DBC_OFF;
          phase_q <= 1'b1;
          drive_q <= '0;
        end else begin
          state_q <= state_d;
          phase_q <= phase_d;
          drive_q <= drive_d;
        end
      end

      assign drive_o[b] = drive_q;
      assign level_o[b] = level;
      assign state_all[b] = state_q;
      assign trip_all[b] = trip;
    end
  endgenerate

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------

  // state codes, thermal latch, synchronised trips and levels
  always_comb begin
    status_word = '0;
    status_word[`DBC_ST_STATE0_LSB +: 3] = state_all[0];
    status_word[`DBC_ST_STATE1_LSB +: 3] = state_all[1];
    status_word[`DBC_ST_THERM_BIT] = therm_q;
    status_word[`DBC_ST_TRIP_LSB +: 2] = trip_all;
    status_word[`DBC_ST_LEVEL_LSB +: 4] = level_o;
  end

endmodule

// [tb/dbc_top_assertions.sv]
// port-level checks for the dual bridge chopper control block
`include "dbc_cfg.svh"
module dbc_top_chk
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire dbc_pins_s [`DBC_NUM_BRIDGES-1:0] pins_i,
  input wire logic temp_hot_i,
  input wire logic temp_cool_i,
  input wire dbc_drive_s [`DBC_NUM_BRIDGES-1:0] drive_o,
  input wire dbc_level_e [`DBC_NUM_BRIDGES-1:0] level_o,
  input wire logic therm_off_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] up_q; // cycles since reset, saturating
  logic [2:0] up_d;
  logic warm; // synchronisers have flushed the reset ones
  dbc_pins_s p0; // bridge 0 pins
  dbc_drive_s d0; // bridge 0 drive
  assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  assign warm = (up_q == 3'h7);
  assign p0 = pins_i[0];
  assign d0 = drive_o[0];
  // warm-up counter, so pin-to-output checks skip the flush
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) up_q <= 3'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_full;
    d0.bridge_oe_a && d0.bridge_oe_b;
  endsequence
  property p_enoff;
    (warm && p0.enable_n) [*5] |-> d0 == '0;
  endproperty
  a_enoff: assert property (p_enoff) else $error("enable high but bridge driven");
  property p_zero;
    (warm && p0.current_sel_lo && p0.current_sel_hi) [*5] |-> d0 == '0 && level_o[0] == DBC_LVL_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("zero code but bridge driven");
  property p_level;
    (warm && $stable({p0.current_sel_hi, p0.current_sel_lo})) [*3]
      |-> level_o[0] == dbc_level_e'({p0.current_sel_hi, p0.current_sel_lo});
  endproperty
  a_level: assert property (p_level) else $error("level decode wrong");
  property p_phase;
    s_full |-> d0.bridge_out_a == $past(p0.phase, 3) && d0.bridge_out_b != d0.bridge_out_a;
  endproperty
  a_phase: assert property (p_phase) else $error("outputs do not follow phase");
  property p_chop;
    d0.bridge_oe_a != d0.bridge_oe_b |-> !d0.bridge_out_a && !d0.bridge_out_b;
  endproperty
  a_chop: assert property (p_chop) else $error("off interval drives a high side");
  property p_trip;
    (warm && p0.trip) [*4] |-> !(d0.bridge_oe_a && d0.bridge_oe_b);
  endproperty
  a_trip: assert property (p_trip) else $error("source on while tripped");
  property p_therm;
    therm_off_o [*3] |-> drive_o == '0;
  endproperty
  a_therm: assert property (p_therm) else $error("driven during thermal shutdown");
  property p_therm_set;
    $rose(therm_off_o) |-> $past(temp_hot_i, 2) || $past(temp_hot_i, 3);
  endproperty
  a_therm_set: assert property (p_therm_set) else $error("shutdown without hot flag");
  property p_therm_clr;
    $fell(therm_off_o) |-> $past(temp_cool_i, 2) || $past(temp_cool_i, 3);
  endproperty
  a_therm_clr: assert property (p_therm_clr) else $error("shutdown left without cool flag");
endmodule

bind dbc_top dbc_top_chk dbc_top_chk_i (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .pins_i(pins_i),
  .temp_hot_i(temp_hot_i),
  .temp_cool_i(temp_cool_i),
  .drive_o(drive_o),
  .level_o(level_o),
  .therm_off_o(therm_off_o)
);

// [tb/dbc_winding.sv]
// behavioural windings and sense comparators for both bridges
module dbc_winding
  import dbc_pkg::*;
#(
  parameter int TRIP_LEVEL = 40
) (
  input wire logic clock_i,
  input wire dbc_drive_s [1:0] drive_i,
  output logic [1:0] trip_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cur [2] = '{0, 0}; // winding current, one unit per cycle of slope
  initial trip_o = 2'h0;
  // source on ramps up; sink-only decays slowly, so a short off time stays tripped
  always @(posedge clock_i) begin
    for (int b = 0; b < 2; b++) begin
      if (drive_i[b] == '0) cur[b] <= 0; // all off: fast decay
      else if (drive_i[b].bridge_oe_a && drive_i[b].bridge_oe_b) cur[b] <= cur[b] + 1;
      else if (cur[b] > 0) cur[b] <= cur[b] - 1; // recirculation through sink
      trip_o[b] <= (cur[b] >= TRIP_LEVEL); // comparator, registered
    end
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the dual bridge chopper control block
`include "dbc_cfg.svh"
module tb_top
  import dbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] ph, en, lo, hi;
    logic [7:0] drv;
    logic [3:0] lvl;
  } dbc_row_s;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic temp_hot_i = 1'b0;
  logic temp_cool_i = 1'b0;
  logic [1:0] ph = 2'h0, en_n = 2'h3, s_lo = 2'h3, s_hi = 2'h3; // controller pins
  logic [1:0] trip_w; // comparator outputs from the winding model
  logic [31:0] rdata_o;
  logic therm_off_o;
  dbc_pins_s [1:0] pins_i;
  dbc_drive_s [1:0] drive_o;
  dbc_level_e [1:0] level_o;
  int miscompares = 0;
  int n_tests = 0;
  dbc_row_s rows [6] = '{
    '{2'h1, 2'h3, 2'h0, 2'h0, 8'h00, 4'h0}, // enable off
    '{2'h1, 2'h0, 2'h0, 2'h0, 8'h7d, 4'h0}, // full current
    '{2'h2, 2'h0, 2'h3, 2'h0, 8'hd7, 4'h5}, // two thirds
    '{2'h1, 2'h0, 2'h0, 2'h3, 8'h7d, 4'ha}, // one third
    '{2'h1, 2'h0, 2'h3, 2'h3, 8'h00, 4'hf}, // zero code
    '{2'h1, 2'h2, 2'h1, 2'h2, 8'h0d, 4'h9}}; // one bridge off
  initial forever #2.5 clock_i = ~clock_i;
  // pins struct assembled from the controller levels and model trip
  always_comb begin
    for (int b = 0; b < 2; b++) pins_i[b] = {ph[b], en_n[b], s_lo[b], s_hi[b], trip_w[b]};
  end
  dbc_top dbc_top_i (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins_i), .temp_hot_i(temp_hot_i),
    .temp_cool_i(temp_cool_i), .drive_o(drive_o), .level_o(level_o), .therm_off_o(therm_off_o));
  dbc_winding dbc_winding_i (.clock_i(clock_i), .drive_i(drive_o), .trip_o(trip_w));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask
  task automatic pins(input logic [1:0] p, e, l, h);
    @(posedge clock_i);
    ph <= p;
    en_n <= e;
    s_lo <= l;
    s_hi <= h;
  endtask
  // bounded wait for a drive pattern; n counts the cycles it took
  task automatic wait_drv(input int b, input logic [3:0] exp, output int n);
    n = 0;
    while (drive_o[b] !== exp) begin
      tick(1);
      n++;
      if (n > 3000) begin
        miscompares++;
        final_report();
      end
    end
  endtask
  // one chopping cycle on bridge 0 with off time n
  task automatic chop(input int n, input int lo_c, input int hi_c);
    int k;
    wr(`DBC_OFFTIME0_ADDR, 32'(n));
    pins(2'h1, 2'h2, 2'h0, 2'h0); // enable held low, full level
    wait_drv(0, 4'b1101, k);
    wait_drv(0, 4'b0001, k);
    chk("trip to off", 32'h1, 32'(k <= 40 + `DBC_TRIP_LAT_CYC));
    wait_drv(0, 4'b1101, k);
    chk("off cycles", 32'h1, 32'(k >= lo_c && k <= hi_c));
    pins(2'h1, 2'h3, 2'h0, 2'h0);
    tick(8);
  endtask
  initial begin
    int k;
    tick(3);
    chk("reset drive", 32'h0, 32'(drive_o));
    chk("reset level", 32'hf, 32'(level_o));
    resetn_i <= 1'b1;
    rd(`DBC_OFFTIME0_ADDR, 32'h7d0, "offtime0");
    rd(`DBC_OFFTIME1_ADDR, 32'h7d0, "offtime1");
    rd(`DBC_CTRL_ADDR, 32'h0, "ctrl");
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'h0, "unmapped");
    rd(`DBC_STATUS_ADDR, 32'hf000, "status");
    tick(1);
    chk("rdata after", 32'h0, rdata_o);
    // ordinary pin combinations, each entered from all-off
    foreach (rows[i]) begin
      pins(2'h0, 2'h3, 2'h0, 2'h0);
      tick(8);
      pins(rows[i].ph, rows[i].en, rows[i].lo, rows[i].hi);
      tick(8);
      chk("drive", 32'(rows[i].drv), 32'(drive_o));
      chk("level", 32'(rows[i].lvl), 32'(level_o));
    end
    pins(2'h0, 2'h3, 2'h0, 2'h0);
    tick(8);
    chop(20, 20, 21);
    chop(1, 3, 40); // off time too short: held until trip clears
    // phase reversal while conducting
    pins(2'h1, 2'h0, 2'h0, 2'h0);
    tick(8);
    pins(2'h0, 2'h0, 2'h0, 2'h0);
    tick(8);
    chk("dead drive", 32'h0, 32'(drive_o[0]));
    wait_drv(0, 4'b0111, k);
    chk("dead time", 32'h1, 32'(k >= `DBC_DEAD_CYC - 8 && k <= `DBC_DEAD_CYC - 4));
    pins(2'h0, 2'h3, 2'h0, 2'h0);
    tick(8);
    pins(2'h0, 2'h0, 2'h0, 2'h0);
    wr(`DBC_CTRL_ADDR, 32'h1);
    tick(4);
    chk("forced off", 32'h70, 32'(drive_o));
    rd(`DBC_CTRL_ADDR, 32'h1, "ctrl");
    rd(`DBC_STATUS_ADDR, 32'h20, "status drive");
    wr(`DBC_CTRL_ADDR, 32'h0);
    // thermal latch with hysteresis
    temp_hot_i <= 1'b1;
    tick(6);
    chk("therm on", 32'h1, 32'(therm_off_o));
    chk("therm drive", 32'h0, 32'(drive_o));
    @(posedge clock_i);
    temp_hot_i <= 1'b0;
    tick(6);
    chk("therm held", 32'h1, 32'(therm_off_o));
    @(posedge clock_i);
    temp_cool_i <= 1'b1;
    tick(8);
    chk("therm clear", 32'h0, 32'(therm_off_o));
    chk("drive back", 32'h77, 32'(drive_o));
    @(posedge clock_i);
    temp_cool_i <= 1'b0;
    resetn_i <= 1'b0;
    tick(2);
    chk("mid reset drive", 32'h0, 32'(drive_o));
    resetn_i <= 1'b1;
    rd(`DBC_OFFTIME0_ADDR, 32'h7d0, "offtime0 again");
    final_report();
  end
endmodule
